// file: logic/flash_read_pkg.sv
// constants for the flash read and status port
// assumes one core clock; pin timing comes from the host's link clock
`default_nettype none

package flash_read_pkg;

    // ****
    // opcodes
    // ****
    localparam logic [7:0] OP_PAGE_READ_A = 8'h52;
    localparam logic [7:0] OP_PAGE_READ_B = 8'hd2;
    localparam logic [7:0] OP_BURST_READ_A = 8'h69;
    localparam logic [7:0] OP_BURST_READ_B = 8'he9;
    localparam logic [7:0] OP_BUF1_READ_A = 8'h54;
    localparam logic [7:0] OP_BUF1_READ_B = 8'hd4;
    localparam logic [7:0] OP_BUF2_READ_A = 8'h56;
    localparam logic [7:0] OP_BUF2_READ_B = 8'hd6;
    localparam logic [7:0] OP_STATUS_A = 8'h57;
    localparam logic [7:0] OP_STATUS_B = 8'hd7;

    // ****
    // geometry
    // ****
    localparam int PAGE_W = 13;
    localparam int BYTE_W = 11;
    localparam logic [10:0] LAST_BYTE = 11'h41f;
    localparam int ADDR_LSB_PAGE = 11;

    // ****
    // phase lengths, in link clocks, minus one
    // ****
    localparam logic [6:0] SER_OPC_LAST = 7'h07;
    localparam logic [6:0] PAR_OPC_LAST = 7'h00;
    localparam logic [6:0] SER_ADDR_LAST = 7'h17;
    localparam logic [6:0] PAR_ADDR_LAST = 7'h02;
    localparam logic [6:0] SER_ARR_DUMMY_LAST = 7'h1f;
    localparam logic [6:0] PAR_ARR_DUMMY_LAST = 7'h3b;
    localparam logic [6:0] SER_BUF_DUMMY_LAST = 7'h07;
    localparam logic [6:0] PAR_BUF_DUMMY_LAST = 7'h00;
    localparam logic [6:0] GAP_LAST = 7'h1f;
    localparam logic [2:0] BIT_MSB = 3'h7;

    // ****
    // status byte layout
    // ****
    localparam int ST_READY_BIT = 7;
    localparam int ST_COMPARE_BIT = 6;
    localparam logic [1:0] ST_RESERVED = 2'h0;
    // arbitrary density code value
    localparam logic [3:0] DENSITY_CODE_DEFAULT = 4'ha;

    // ****
    // memory targets
    // ****
    localparam logic [1:0] TGT_ARRAY = 2'h0;
    localparam logic [1:0] TGT_BUF1 = 2'h1;
    localparam logic [1:0] TGT_BUF2 = 2'h2;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_OPC = 7'h02,
        ST_ADDR = 7'h04,
        ST_DUMMY = 7'h08,
        ST_DATA = 7'h10,
        ST_GAP = 7'h20,
        ST_IGNORE = 7'h40
    } phase_e;

    typedef enum logic [3:0] {
        MD_PAGE = 4'h1,
        MD_BURST = 4'h2,
        MD_BUFFER = 4'h4,
        MD_STATUS = 4'h8
    } mode_e;

endpackage : flash_read_pkg

`default_nettype wire

// file: logic/flash_read_port.sv
// read side of a paged flash command port: page, burst, buffer and status reads
// assumes the host drives select, link clock and data pins (mode 0 timing);
// array and sram buffers sit behind a read-only request/response port
`default_nettype none

module flash_read_port
    import flash_read_pkg::*;
#(
    parameter logic [3:0] DENSITY_CODE = DENSITY_CODE_DEFAULT
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // host pins
    input wire logic selectN,
    input wire logic linkClk,
    input wire logic parallelMode,
    input wire logic serialIn,
    input wire logic [7:0] parallel_data_pins_in,
    output logic serialOut,
    output logic serialOutEn,
    output logic [7:0] parallel_data_pins_out,
    output logic parallel_data_pins_oe,
    // device state feeding status
    input wire logic [7:0] selfTimedBusy,
    input wire logic compareMismatch,
    output logic [7:0] flash_status,
    // memory read port
    output logic memReqValid,
    input wire logic memReqReady,
    output logic [1:0] memReqTarget,
    output logic [PAGE_W-1:0] page_index,
    output logic [BYTE_W-1:0] byte_in_page_index,
    input wire logic memRespValid,
    output logic memRespReady,
    input wire logic [7:0] memRespData
);

    // ****
    // pin synchronisers
    // ****
    logic [11:0] pinsS;
    logic selS;
    logic clkS;
    logic parS;
    logic siS;
    logic [7:0] pdS;

    pin_sync #(.WIDTH(12)) u_sync (
        .core_clk(core_clk),
        .reset(reset),
        .pinIn({selectN, linkClk, parallelMode, serialIn, parallel_data_pins_in}),
        .syncOut(pinsS)
    );
    assign {selS, clkS, parS, siS, pdS} = pinsS;

    // ****
    // state
    // ****
    phase_e phase_r, phase_nxt;
    mode_e mode_r, mode_nxt;
    logic clkPrev_r, clkPrev_nxt;
    logic selPrev_r, selPrev_nxt;
    logic [6:0] cnt_r, cnt_nxt;
    logic [6:0] dummyLast_r, dummyLast_nxt;
    logic [23:0] inShift_r, inShift_nxt;
    logic [7:0] outByte_r, outByte_nxt;
    logic outLast_r, outLast_nxt;
    logic [2:0] bitIdx_r, bitIdx_nxt;
    logic sOut_r, sOut_nxt;
    logic sOe_r, sOe_nxt;
    logic [7:0] pOut_r, pOut_nxt;
    logic pOe_r, pOe_nxt;
    logic [7:0] status_r, status_nxt;
    logic [1:0] target_r, target_nxt;
    logic addrDone;
    logic [23:0] addrWord;

    // fetch side
    logic fetchOn_r, fetchOn_nxt;
    logic reqValid_r, reqValid_nxt;
    logic pending_r, pending_nxt;
    logic stale_r, stale_nxt;
    logic pendLast_r, pendLast_nxt;
    logic [PAGE_W-1:0] page_r, page_nxt;
    logic [BYTE_W-1:0] byte_r, byte_nxt;

    // buffer between memory and shifter
    logic bufInReady;
    logic bufOutValid;
    logic [8:0] bufOutData;
    logic pop;
    logic pushResp;

    logic rise;
    logic fall;
    logic ready;
    logic [7:0] statusNow;
    logic [7:0] newByte;
    logic [23:0] newWord;
    logic [6:0] unitOpcLast;
    logic [6:0] unitAddrLast;
    logic byteDone;

    assign rise = clkS && !clkPrev_r;
    assign fall = !clkS && clkPrev_r;
    assign ready = !(|selfTimedBusy);
    assign statusNow = {ready, compareMismatch, DENSITY_CODE, ST_RESERVED};
    // shift in msb first; parallel takes a whole byte per clock
    assign newByte = parS ? pdS : {inShift_r[6:0], siS};
    assign newWord = parS ? {inShift_r[15:0], pdS} : {inShift_r[22:0], siS};
    assign unitOpcLast = parS ? PAR_OPC_LAST : SER_OPC_LAST;
    assign unitAddrLast = parS ? PAR_ADDR_LAST : SER_ADDR_LAST;
    assign byteDone = parS || (bitIdx_r == '0);

    // ****
    // command sequencer and pin drive
    // ****
    always_comb begin
        phase_nxt = phase_r;
        mode_nxt = mode_r;
        clkPrev_nxt = clkS;
        selPrev_nxt = selS;
        cnt_nxt = cnt_r;
        dummyLast_nxt = dummyLast_r;
        inShift_nxt = inShift_r;
        outByte_nxt = outByte_r;
        outLast_nxt = outLast_r;
        bitIdx_nxt = bitIdx_r;
        sOut_nxt = sOut_r;
        sOe_nxt = sOe_r;
        pOut_nxt = pOut_r;
        pOe_nxt = pOe_r;
        status_nxt = statusNow;
        target_nxt = target_r;
        addrDone = 1'b0;
        addrWord = newWord;
        pop = 1'b0;
        if (selS) begin
            // select high aborts any command and floats the pins
            phase_nxt = ST_IDLE;
            sOe_nxt = 1'b0;
            pOe_nxt = 1'b0;
        end else begin
            unique case (phase_r)
                ST_IDLE: begin
                    if (selPrev_r) begin
                        phase_nxt = ST_OPC;
                        cnt_nxt = '0;
                    end
                end
                ST_OPC: begin
                    if (rise) begin
                        inShift_nxt = newWord;
                        cnt_nxt = cnt_r + 1'b1;
                        if (cnt_r == unitOpcLast) begin
                            cnt_nxt = '0;
                            phase_nxt = ST_ADDR;
                            unique case (newByte)
                                OP_PAGE_READ_A, OP_PAGE_READ_B: begin
                                    mode_nxt = MD_PAGE;
                                    target_nxt = TGT_ARRAY;
                                end
                                OP_BURST_READ_A, OP_BURST_READ_B: begin
                                    mode_nxt = MD_BURST;
                                    target_nxt = TGT_ARRAY;
                                end
                                OP_BUF1_READ_A, OP_BUF1_READ_B: begin
                                    mode_nxt = MD_BUFFER;
                                    target_nxt = TGT_BUF1;
                                end
                                OP_BUF2_READ_A, OP_BUF2_READ_B: begin
                                    mode_nxt = MD_BUFFER;
                                    target_nxt = TGT_BUF2;
                                end
                                OP_STATUS_A, OP_STATUS_B: begin
                                    // status goes out from the next clock
                                    mode_nxt = MD_STATUS;
                                    phase_nxt = ST_DATA;
                                    outByte_nxt = statusNow;
                                    bitIdx_nxt = BIT_MSB;
                                end
                                default: begin
                                    phase_nxt = ST_IGNORE;
                                end
                            endcase
                        end
                    end
                end
                ST_ADDR: begin
                    if (rise) begin
                        inShift_nxt = newWord;
                        cnt_nxt = cnt_r + 1'b1;
                        if (cnt_r == unitAddrLast) begin
                            cnt_nxt = '0;
                            addrDone = 1'b1;
                            phase_nxt = ST_DUMMY;
                            if (mode_r == MD_BUFFER) begin
                                dummyLast_nxt = parS ? PAR_BUF_DUMMY_LAST
                                                     : SER_BUF_DUMMY_LAST;
                            end else begin
                                dummyLast_nxt = parS ? PAR_ARR_DUMMY_LAST
                                                     : SER_ARR_DUMMY_LAST;
                            end
                        end
                    end
                end
                ST_DUMMY: begin
                    if (rise) begin
                        cnt_nxt = cnt_r + 1'b1;
                        if (cnt_r == dummyLast_r) begin
                            phase_nxt = ST_DATA;
                            pop = 1'b1;
                            outByte_nxt = bufOutData[7:0];
                            outLast_nxt = bufOutData[8];
                            bitIdx_nxt = BIT_MSB;
                        end
                    end
                end
                ST_DATA: begin
                    if (rise) begin
                        bitIdx_nxt = bitIdx_r - 1'b1;
                        if (byteDone) begin
                            bitIdx_nxt = BIT_MSB;
                            if (mode_r == MD_STATUS) begin
                                outByte_nxt = statusNow;
                            end else if (mode_r == MD_BURST && outLast_r) begin
                                // host owes dummy clocks at each page and array end
                                phase_nxt = ST_GAP;
                                cnt_nxt = '0;
                            end else begin
                                pop = 1'b1;
                                outByte_nxt = bufOutData[7:0];
                                outLast_nxt = bufOutData[8];
                            end
                        end
                    end
                    if (fall) begin
                        sOut_nxt = outByte_r[bitIdx_r];
                        pOut_nxt = outByte_r;
                        sOe_nxt = !parS;
                        pOe_nxt = parS;
                    end
                    // clock parked low on bit 7: keep the ready level live
                    if (mode_r == MD_STATUS && bitIdx_r == BIT_MSB && (sOe_r || pOe_r)
                            && !clkS) begin
                        sOut_nxt = ready;
                        pOut_nxt[ST_READY_BIT] = ready;
                    end
                end
                ST_GAP: begin
                    if (rise) begin
                        cnt_nxt = cnt_r + 1'b1;
                        if (cnt_r == GAP_LAST) begin
                            phase_nxt = ST_DATA;
                            pop = 1'b1;
                            outByte_nxt = bufOutData[7:0];
                            outLast_nxt = bufOutData[8];
                        end
                    end
                end
                ST_IGNORE: begin
                end
            endcase
        end
    end

    // ****
    // fetch address walk
    // ****
    always_comb begin
        fetchOn_nxt = fetchOn_r;
        reqValid_nxt = reqValid_r;
        pending_nxt = pending_r;
        stale_nxt = stale_r;
        pendLast_nxt = pendLast_r;
        page_nxt = page_r;
        byte_nxt = byte_r;
        pushResp = memRespValid && pending_r && !stale_r;
        if (memRespValid && pending_r) begin
            pending_nxt = 1'b0;
            stale_nxt = 1'b0;
        end
        if (addrDone) begin
            fetchOn_nxt = 1'b1;
            page_nxt = addrWord[23:ADDR_LSB_PAGE];
            byte_nxt = addrWord[BYTE_W-1:0];
        end else if (reqValid_r && memReqReady) begin
            reqValid_nxt = 1'b0;
            pending_nxt = 1'b1;
            pendLast_nxt = (byte_r >= LAST_BYTE);
            if (byte_r >= LAST_BYTE) begin
                byte_nxt = '0;
                if (mode_r == MD_BURST) begin
                    page_nxt = page_r + 1'b1;
                end
            end else begin
                byte_nxt = byte_r + 1'b1;
            end
        end else if (fetchOn_r && !reqValid_r && !pending_r && bufInReady) begin
            reqValid_nxt = 1'b1;
        end
        // an abort leaves an answer in flight; swallow it when it lands
        if (selS) begin
            fetchOn_nxt = 1'b0;
            reqValid_nxt = 1'b0;
            if (pending_r && !memRespValid) begin
                stale_nxt = 1'b1;
            end
        end
    end

    two_entry_buffer #(.WIDTH(9), .DEPTH(2)) u_buf (
        .core_clk(core_clk),
        .reset(reset),
        .flush(selS),
        .inValid(pushResp),
        .inReady(bufInReady),
        .inData({pendLast_r, memRespData}),
        .outValid(bufOutValid),
        .outReady(pop),
        .outData(bufOutData)
    );

    always_ff @(posedge core_clk) begin
        if (reset) begin
            phase_r <= ST_IDLE;
            mode_r <= MD_STATUS;
            clkPrev_r <= 1'b1;
            selPrev_r <= 1'b1;
            cnt_r <= '0;
            dummyLast_r <= '0;
            inShift_r <= '0;
            outByte_r <= '0;
            outLast_r <= 1'b0;
            bitIdx_r <= BIT_MSB;
            sOut_r <= 1'b0;
            sOe_r <= 1'b0;
            pOut_r <= '0;
            pOe_r <= 1'b0;
            status_r <= '0;
            target_r <= TGT_ARRAY;
            fetchOn_r <= 1'b0;
            reqValid_r <= 1'b0;
            pending_r <= 1'b0;
            stale_r <= 1'b0;
            pendLast_r <= 1'b0;
            page_r <= '0;
            byte_r <= '0;
        end else begin
            phase_r <= phase_nxt;
            mode_r <= mode_nxt;
            clkPrev_r <= clkPrev_nxt;
            selPrev_r <= selPrev_nxt;
            cnt_r <= cnt_nxt;
            dummyLast_r <= dummyLast_nxt;
            inShift_r <= inShift_nxt;
            outByte_r <= outByte_nxt;
            outLast_r <= outLast_nxt;
            bitIdx_r <= bitIdx_nxt;
            sOut_r <= sOut_nxt;
            sOe_r <= sOe_nxt;
            pOut_r <= pOut_nxt;
            pOe_r <= pOe_nxt;
            status_r <= status_nxt;
            target_r <= target_nxt;
            fetchOn_r <= fetchOn_nxt;
            reqValid_r <= reqValid_nxt;
            pending_r <= pending_nxt;
            stale_r <= stale_nxt;
            pendLast_r <= pendLast_nxt;
            page_r <= page_nxt;
            byte_r <= byte_nxt;
        end
    end

    // ****
    // outputs
    // ****
    assign serialOut = sOut_r;
    assign serialOutEn = sOe_r;
    assign parallel_data_pins_out = pOut_r;
    assign parallel_data_pins_oe = pOe_r;
    assign flash_status = status_r;
    assign memReqValid = reqValid_r;
    assign memReqTarget = target_r;
    assign page_index = page_r;
    assign byte_in_page_index = byte_r;
    // buffer fill level is registered; stale answers are always taken
    assign memRespReady = bufInReady || stale_r;

endmodule : flash_read_port

`default_nettype wire

// file: logic/pin_sync.sv
// two-stage synchroniser for pin inputs
// assumes inputs arrive asynchronous to core_clk
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // pins and synchronised copy
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] sync_r;
    logic [WIDTH-1:0] sync_nxt;

    always_comb begin
        meta_nxt = pinIn;
        sync_nxt = meta_r;
    end

    // idle level high keeps select deasserted through reset
    always_ff @(posedge core_clk) begin
        if (reset) begin
            meta_r <= '1;
            sync_r <= '1;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign syncOut = sync_r;

endmodule : pin_sync

`default_nettype wire

// file: logic/two_entry_buffer.sv
// small fifo with valid/ready on both sides and a flush
// assumes one clock; flush wins over a push in the same cycle
`default_nettype none

module two_entry_buffer #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 2
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    input wire logic flush,
    // fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0] FULL_COUNT = (PW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [WIDTH-1:0] mem_nxt [DEPTH];
    logic [PW-1:0] wrPtr_r;
    logic [PW-1:0] wrPtr_nxt;
    logic [PW-1:0] rdPtr_r;
    logic [PW-1:0] rdPtr_nxt;
    logic [PW:0] count_r;
    logic [PW:0] count_nxt;
    logic push;
    logic pop;

    assign inReady = (count_r != FULL_COUNT);
    assign outValid = (count_r != '0);
    assign outData = mem_r[rdPtr_r];

    always_comb begin
        push = inValid && inReady;
        pop = outValid && outReady;
        mem_nxt = mem_r;
        wrPtr_nxt = wrPtr_r;
        rdPtr_nxt = rdPtr_r;
        count_nxt = count_r;
        if (flush) begin
            wrPtr_nxt = '0;
            rdPtr_nxt = '0;
            count_nxt = '0;
        end else begin
            if (push) begin
                mem_nxt[wrPtr_r] = inData;
                wrPtr_nxt = (wrPtr_r == PW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
            end
            if (pop) begin
                rdPtr_nxt = (rdPtr_r == PW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
            end
            count_nxt = count_r + (PW + 1)'(push) - (PW + 1)'(pop);
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            wrPtr_r <= wrPtr_nxt;
            rdPtr_r <= rdPtr_nxt;
            count_r <= count_nxt;
        end
        mem_r <= mem_nxt;
    end

endmodule : two_entry_buffer

`default_nettype wire

// file: verif/flash_host_model.sv
// serial host model: select, link clock and serial input pins
// assumes core_clk paces the link; link period is 16 core cycles
`default_nettype none
module flash_host_model (
    // clock
    input wire logic core_clk,
    // pins
    output logic selectN,
    output logic linkClk,
    output logic serialIn,
    input wire logic serialOut
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        selectN = 1'b1;
        linkClk = 1'b0;
        serialIn = 1'b0;
    end
    task automatic half();
        repeat (8) @(posedge core_clk);
    endtask : half
    task automatic start();
        selectN <= 1'b0;
        half();
    endtask : start
    // sample just before rising
    task automatic xfer(input logic [7:0] b, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            linkClk <= 1'b0;
            serialIn <= b[i];
            half();
            r[i] = serialOut;
            linkClk <= 1'b1;
            half();
        end
    endtask : xfer
    task automatic dropClk();
        linkClk <= 1'b0;
        half();
    endtask : dropClk
    // clock rests low between frames
    task automatic stop();
        linkClk <= 1'b0;
        half();
        selectN <= 1'b1;
        serialIn <= ~serialIn;
        half();
    endtask : stop
endmodule : flash_host_model
`default_nettype wire

// file: verif/flash_read_port_assertions.sv
// checker for status byte, select release and memory request port
// assumes binding into flash_read_port, one clock domain
`default_nettype none
module flash_read_port_assertions
    import flash_read_pkg::*;
#(
    parameter logic [3:0] DENSITY_CODE = DENSITY_CODE_DEFAULT
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // watched ports
    input wire logic selectN,
    input wire logic serialOutEn,
    input wire logic parallel_data_pins_oe,
    input wire logic [7:0] selfTimedBusy,
    input wire logic compareMismatch,
    input wire logic [7:0] flash_status,
    input wire logic memReqValid,
    input wire logic memReqReady,
    input wire logic [BYTE_W-1:0] byte_in_page_index,
    input wire logic memRespValid,
    input wire logic memRespReady
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // six samples cover the two sync stages plus the enable flop
    sequence selHigh; selectN [*6]; endsequence
    sequence reqStall; memReqValid && !memReqReady && !$past(selectN); endsequence
    AST_READY_IDLE: assert property (selfTimedBusy == 8'h00 |=> flash_status[7])
        else $error("ready bit low while idle");
    AST_BUSY_ANY: assert property (selfTimedBusy != 8'h00 |=> !flash_status[7])
        else $error("ready bit high while busy");
    AST_COMPARE: assert property (1 |=> flash_status[6] == $past(compareMismatch))
        else $error("compare bit wrong");
    AST_DENSITY: assert property (1 |=> flash_status[5:2] == DENSITY_CODE)
        else $error("density code wrong");
    AST_RESERVED: assert property (1 |=> flash_status[1:0] == ST_RESERVED)
        else $error("reserved bits not zero");
    AST_SEL_OFF: assert property (selHigh |-> !serialOutEn && !parallel_data_pins_oe)
        else $error("outputs driven with select high");
    AST_REQ_HOLD: assert property (reqStall |=> memReqValid && $stable(byte_in_page_index))
        else $error("request dropped before accept");
    AST_RESP_TAKEN: assert property (memRespValid |-> memRespReady)
        else $error("response not taken");
endmodule : flash_read_port_assertions
bind flash_read_port flash_read_port_assertions #(.DENSITY_CODE(DENSITY_CODE)) chk (
    .core_clk(core_clk), .reset(reset), .selectN(selectN), .serialOutEn(serialOutEn),
    .parallel_data_pins_oe(parallel_data_pins_oe), .selfTimedBusy(selfTimedBusy),
    .compareMismatch(compareMismatch), .flash_status(flash_status),
    .memReqValid(memReqValid), .memReqReady(memReqReady),
    .byte_in_page_index(byte_in_page_index), .memRespValid(memRespValid),
    .memRespReady(memRespReady));
`default_nettype wire

// file: verif/test_flash_read_and_status_port.sv
// self-checking bench for the flash read and status port
// assumes host model on the pins and a stalling memory model below
`default_nettype none
module test_flash_read_and_status_port import flash_read_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0] DENS = 4'h5;
    typedef struct {logic [7:0] op; logic [12:0] pg; logic [10:0] by; logic [1:0] tgt;
        int dum;} row_s;
    row_s rows [6] = '{'{OP_PAGE_READ_A, 13'h0005, 11'h41e, TGT_ARRAY, 4},
        '{OP_PAGE_READ_B, 13'h1fff, 11'h003, TGT_ARRAY, 4},
        '{OP_BUF1_READ_A, 13'h1abc, 11'h41f, TGT_BUF1, 1},
        '{OP_BUF1_READ_B, 13'h0000, 11'h000, TGT_BUF1, 1},
        '{OP_BUF2_READ_A, 13'h0123, 11'h41e, TGT_BUF2, 1},
        '{OP_BUF2_READ_B, 13'h0001, 11'h200, TGT_BUF2, 1}};
    logic core_clk = 1'b0, reset = 1'b1, cmp = 1'b0, memReqReady = 1'b0;
    logic memRespValid = 1'b0, selectN, linkClk, serialIn, serialOut, serialOutEn;
    logic memReqValid, memRespReady;
    logic [7:0] busy = 8'h00, memRespData = 8'h00, flash_status, r;
    logic [1:0] memReqTarget;
    logic [12:0] page_index;
    logic [10:0] byte_in_page_index, b;
    int fails = 0, numChecks = 0;
    flash_host_model host (.core_clk(core_clk), .selectN(selectN), .linkClk(linkClk),
        .serialIn(serialIn), .serialOut(serialOut));
    flash_read_port #(.DENSITY_CODE(DENS)) DUT (.core_clk(core_clk), .reset(reset),
        .selectN(selectN), .linkClk(linkClk), .parallelMode(1'b0), .serialIn(serialIn),
        .parallel_data_pins_in(8'h00), .serialOut(serialOut), .serialOutEn(serialOutEn),
        .parallel_data_pins_out(), .parallel_data_pins_oe(), .selfTimedBusy(busy),
        .compareMismatch(cmp), .flash_status(flash_status), .memReqValid(memReqValid),
        .memReqReady(memReqReady), .memReqTarget(memReqTarget), .page_index(page_index),
        .byte_in_page_index(byte_in_page_index), .memRespValid(memRespValid),
        .memRespReady(memRespReady), .memRespData(memRespData));
    // buffers ignore the page field
    function automatic logic [7:0] dat(logic [1:0] t, logic [12:0] p, logic [10:0] a);
        return {t, t == TGT_ARRAY ? p[5:0] : 6'h00} ^ a[7:0] ^ {a[10:8], 5'h00};
    endfunction : dat
    // memory: ready every other cycle, answer one cycle later
    always @(posedge core_clk) begin
        memReqReady <= ~memReqReady & ~reset;
        memRespValid <= memReqValid & memReqReady;
        memRespData <= dat(memReqTarget, page_index, byte_in_page_index);
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        numChecks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int dum);
        host.start();
        host.xfer(op, r);
        for (int i = 2; i >= 0; i--) host.xfer(a[i*8+:8], r);
        repeat (dum) host.xfer(8'h00, r);
    endtask : cmd
    task automatic wrapUp();
        if (fails == 0 && numChecks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrapUp
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        repeat (12) @(posedge core_clk);
        check(flash_status, 8'h00);
        reset <= 1'b0;
        repeat (4) @(posedge core_clk);
        foreach (rows[n]) begin
            cmd(rows[n].op, {rows[n].pg, rows[n].by}, rows[n].dum);
            for (int k = 0; k < 3; k++) begin
                b = rows[n].by + 11'(k);
                if (b > LAST_BYTE) b = b - 11'h420;
                host.xfer(8'h00, r);
                check(r, dat(rows[n].tgt, rows[n].pg, b));
            end
            host.stop();
        end
        for (int j = 0; j < 2; j++) begin
            cmd(j ? OP_BURST_READ_B : OP_BURST_READ_A, {13'h1fff - 13'(j), 11'h41f}, 4);
            host.xfer(8'h00, r);
            check(r, dat(TGT_ARRAY, 13'h1fff - 13'(j), 11'h41f));
            repeat (4) host.xfer(8'h00, r);
            host.xfer(8'h00, r);
            check(r, dat(TGT_ARRAY, 13'(j) * 13'h1fff, 11'h000));
            host.stop();
        end
        for (int i = 0; i < 8; i++) begin
            busy <= 8'h01 << i;
            repeat (3) @(posedge core_clk);
            check({7'h00, flash_status[7]}, 8'h00);
        end
        busy <= 8'h04;
        cmp <= 1'b1;
        host.start();
        host.xfer(OP_STATUS_A, r);
        host.xfer(8'h00, r);
        check(r, {2'b01, DENS, ST_RESERVED});
        busy <= 8'h00;
        cmp <= 1'b0;
        repeat (2) host.xfer(8'h00, r);
        check(r, {2'b10, DENS, ST_RESERVED});
        host.stop();
        busy <= 8'h80;
        host.start();
        host.xfer(OP_STATUS_B, r);
        host.dropClk();
        check({serialOutEn, serialOut}, 2'b10);
        busy <= 8'h00;
        repeat (4) @(posedge core_clk);
        check({serialOutEn, serialOut}, 2'b11);
        host.stop();
        check({7'h00, serialOutEn}, 8'h00);
        wrapUp();
    end
endmodule : test_flash_read_and_status_port
`default_nettype wire
